/* File: verilog/bfsc_top.sv */
// supervisory control: startup, protection, power good, sync
`timescale 1ns/1ps
`include "bfsc_regs.svh"
module bfsc_top (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  // comparator pins
  input  wire logic       vcc_ok_in,
  input  wire logic       enable_ok_in,
  input  wire logic       ss_low_in,
  input  wire logic       ss_delay_in,
  input  wire logic       ocset_neg_in,
  input  wire logic       overtemp_in,
  input  wire logic       sense_window_in,
  input  wire logic       sense_over_in,
  input  wire logic       sense_release_in,
  // timing inputs
  input  wire logic       ext_clk_in,
  input  wire logic [7:0] freq_resistor_period_in,
  input  wire logic [7:0] duty_in,
  // gate and soft-start control
  output logic            hs_on_out,
  output logic            ls_on_out,
  output logic            drv_hiz_out,
  output logic            ss_discharge_out,
  // status
  output logic            overcurrent_trip_out,
  output logic            overvoltage_trip_out,
  output logic            power_on_ready_out,
  output logic            ext_sync_active_out,
  // open-drain power good
  input  wire logic       power_good_in,
  output logic            power_good_out,
  output logic            power_good_oe_n_out,
  output logic            power_good_level_out
);
  // ========================================================
  // synchronisers and cycle sampling
  logic [10:0] pins_s;
  logic        vcc_s, en_s, ssl_s, ssd_s, ocn_s, tsd_s;
  logic        win_s, ovr_s, rel_s, ext_s, pgp_s;
  logic        por_t, ssl_t, ssd_t, tsd_t, win_t, ovr_t, rel_t;
  logic        tick;
  logic [7:0]  phase, period;

  bfsc_sync3 #(.W(11)) u_sync (
    .clk_in    (clk_in),
    .nrst_in   (nrst_in),
    .pin_in    ({vcc_ok_in, enable_ok_in, ss_low_in, ss_delay_in,
                 ocset_neg_in, overtemp_in, sense_window_in,
                 sense_over_in, sense_release_in, ext_clk_in,
                 power_good_in}),
    .level_out (pins_s)
  );
  assign {vcc_s, en_s, ssl_s, ssd_s, ocn_s, tsd_s,
          win_s, ovr_s, rel_s, ext_s, pgp_s} = pins_s;
  assign power_good_level_out = pgp_s;

  // slow comparators only matter once per switching cycle
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      por_t <= 1'b0;
      ssl_t <= 1'b0;
      ssd_t <= 1'b0;
      tsd_t <= 1'b0;
      win_t <= 1'b0;
      ovr_t <= 1'b0;
      rel_t <= 1'b0;
    end else if (tick) begin // R25
      por_t <= vcc_s && en_s; // R22
      ssl_t <= ssl_s;
      ssd_t <= ssd_s;
      tsd_t <= tsd_s;
      win_t <= win_s;
      ovr_t <= ovr_s;
      rel_t <= rel_s;
    end
  end
  assign power_on_ready_out = por_t;

  // ========================================================
  // external clock detection and oscillator
  bfsc_pkg::bfsc_state_t state_reg, state_next;
  logic       ext_d_reg, ext_edge;
  logic [8:0] ext_age_reg;
  logic       ext_present;

  assign ext_edge    = ext_s && !ext_d_reg;
  assign ext_present = ext_age_reg < 9'(`BFSC_EXT_TIMEOUT);

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ext_d_reg   <= 1'b0;
      ext_age_reg <= 9'(`BFSC_EXT_TIMEOUT);
    end else begin
      ext_d_reg <= ext_s;
      if (ext_edge) ext_age_reg <= 9'h000;
      else if (ext_present) ext_age_reg <= ext_age_reg + 9'h001;
    end
  end
  // alignment waits for the end of pre-bias startup
  assign ext_sync_active_out =
    ext_present && (state_reg == bfsc_pkg::ST_RUN); // R18

  bfsc_osc u_osc (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .period_in     (freq_resistor_period_in),
    .align_en_in   (ext_sync_active_out),
    .align_edge_in (ext_edge),
    .tick_out      (tick),
    .phase_out     (phase),
    .period_out    (period)
  );

  // ========================================================
  // pwm with minimum on-time and pre-bias low-side steps
  logic [15:0] prod;
  logic [7:0]  on_cyc, off_cyc, ls_lim;
  logic [9:0]  ls_mul;
  logic [2:0]  pb_step_reg, ls_step;
  logic [5:0]  pb_cnt_reg;
  logic        hs_seen_reg, sw_en, hs_req, ls_req;

  assign prod    = 16'(duty_in) * 16'(period);
  assign on_cyc  = prod[15:8];
  assign off_cyc = period - on_cyc;
  // steady state gives the low side the whole off phase
  assign ls_step = (state_reg == bfsc_pkg::ST_RUN) ? 3'h4 : pb_step_reg;
  assign ls_mul  = 10'(off_cyc) * 10'(ls_step);
  assign ls_lim  = ls_mul[9:2];
  assign sw_en   = (state_reg == bfsc_pkg::ST_RUN) ||
                   (state_reg == bfsc_pkg::ST_SOFT && !ssl_t); // R03
  // too short a request is skipped rather than shortened
  assign hs_req  = sw_en && (phase < on_cyc) &&
                   (on_cyc >= 8'(`BFSC_MINON_CYC)); // R21
  assign ls_req  = sw_en && (phase >= on_cyc) &&
                   (phase - on_cyc < ls_lim); // R24

  function automatic logic [5:0] pb_limit(input logic [2:0] s);
    unique case (s)
      3'h1:    pb_limit = 6'(`BFSC_PB_N1);
      3'h2:    pb_limit = 6'(`BFSC_PB_N2);
      default: pb_limit = 6'(`BFSC_PB_N3);
    endcase
  endfunction

  always_ff @(posedge clk_in) begin
    if (!nrst_in || state_reg != bfsc_pkg::ST_SOFT) begin
      pb_step_reg <= 3'h0;
      pb_cnt_reg  <= 6'h00;
      hs_seen_reg <= 1'b0;
    end else if (tick) begin
      hs_seen_reg <= 1'b0;
      if (pb_step_reg == 3'h0) begin
        if (hs_seen_reg) pb_step_reg <= 3'h1; // R24
      end else if (pb_step_reg != 3'h4) begin
        if (pb_cnt_reg == pb_limit(pb_step_reg) - 6'h01) begin
          pb_step_reg <= pb_step_reg + 3'h1;
          pb_cnt_reg  <= 6'h00;
        end else begin
          pb_cnt_reg <= pb_cnt_reg + 6'h01;
        end
      end
    end else if (hs_req) begin
      hs_seen_reg <= 1'b1;
    end
  end

  // ========================================================
  // overcurrent blanking and trip flag
  logic [2:0]  blank_reg;
  logic        oc_sample, oc_clear;
  logic [12:0] hc_cnt_reg;

  always_ff @(posedge clk_in) begin
    if (!nrst_in || !ls_on_out) blank_reg <= 3'h0;
    else if (blank_reg != 3'(`BFSC_BLANK_CYC))
      blank_reg <= blank_reg + 3'h1; // R08
  end
  assign oc_sample = ls_on_out && ocn_s &&
                     blank_reg == 3'(`BFSC_BLANK_CYC); // R04
  assign oc_clear  = state_reg == bfsc_pkg::ST_HICC && tick &&
                     hc_cnt_reg == 13'(`BFSC_HICCUP_CYC - 1);

  // a new trip in the clearing cycle wins
  always_ff @(posedge clk_in) begin
    if (!nrst_in) overcurrent_trip_out <= 1'b0;
    else if (oc_sample) overcurrent_trip_out <= 1'b1; // R05
    else if (oc_clear) overcurrent_trip_out <= 1'b0; // R06
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in || state_reg != bfsc_pkg::ST_HICC) hc_cnt_reg <= 13'h0000;
    else if (tick) hc_cnt_reg <= hc_cnt_reg + 13'h0001; // R06
  end

  // ========================================================
  // sequencing state machine
  always_comb begin
    state_next = state_reg;
    if (!por_t) begin
      state_next = bfsc_pkg::ST_OFF; // R02
    end else begin
      unique case (state_reg)
        bfsc_pkg::ST_OFF:  state_next = bfsc_pkg::ST_SOFT; // R22
        bfsc_pkg::ST_SOFT, bfsc_pkg::ST_RUN: begin
          if (ovr_t) state_next = bfsc_pkg::ST_OVPD; // R15
          else if (tsd_t) state_next = bfsc_pkg::ST_THRM; // R09
          else if (oc_sample) state_next = bfsc_pkg::ST_HICC; // R23
          else if (state_reg == bfsc_pkg::ST_RUN && ssl_t)
            state_next = bfsc_pkg::ST_SOFT; // R03
          else if (pb_step_reg == 3'h4) state_next = bfsc_pkg::ST_RUN;
        end
        bfsc_pkg::ST_HICC: begin
          if (ovr_t) state_next = bfsc_pkg::ST_OVPD;
          else if (oc_clear) state_next = bfsc_pkg::ST_SOFT; // R07
        end
        bfsc_pkg::ST_THRM: begin
          // comparator hysteresis sets the restart point
          if (!tsd_t) state_next = bfsc_pkg::ST_SOFT; // R10
        end
        bfsc_pkg::ST_OVPD: begin
          if (rel_t) state_next = bfsc_pkg::ST_OVPL; // R16
        end
        bfsc_pkg::ST_OVPL: state_next = bfsc_pkg::ST_OVPL; // R16
        default:           state_next = bfsc_pkg::ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) state_reg <= bfsc_pkg::ST_OFF;
    else state_reg <= state_next;
  end

  // ========================================================
  // registered drive outputs
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      hs_on_out            <= 1'b0;
      ls_on_out            <= 1'b0;
      drv_hiz_out          <= 1'b1;
      ss_discharge_out     <= 1'b0;
      overvoltage_trip_out <= 1'b0;
    end else begin
      drv_hiz_out <= state_reg == bfsc_pkg::ST_OFF; // R02
      hs_on_out   <= hs_req;
      ls_on_out   <= ls_req || state_reg == bfsc_pkg::ST_OVPD; // R15
      ss_discharge_out <= state_reg == bfsc_pkg::ST_HICC ||
                          state_reg == bfsc_pkg::ST_THRM; // R09
      overvoltage_trip_out <= state_reg == bfsc_pkg::ST_OVPD ||
                              state_reg == bfsc_pkg::ST_OVPL;
    end
  end

  // ========================================================
  // power good qualification
  logic [8:0] pg_cnt_reg;
  logic       pg_ok, pg_rel_reg;

  assign pg_ok = win_t && ssd_t && (state_reg == bfsc_pkg::ST_RUN ||
                 state_reg == bfsc_pkg::ST_SOFT); // R13
  always_ff @(posedge clk_in) begin
    if (!nrst_in || !pg_ok) pg_cnt_reg <= 9'h000; // R11
    else if (tick && pg_cnt_reg != 9'(`BFSC_PG_DELAY))
      pg_cnt_reg <= pg_cnt_reg + 9'h001; // R14
  end
  always_ff @(posedge clk_in) begin
    if (!nrst_in) pg_rel_reg <= 1'b0;
    else pg_rel_reg <= pg_ok && pg_cnt_reg == 9'(`BFSC_PG_DELAY);
  end
  // driven low unless good; released pin is pulled high outside
  assign power_good_out      = 1'b0; // R12
  assign power_good_oe_n_out = pg_rel_reg; // R12

  // ========================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_ovp_enter;
    state_reg == bfsc_pkg::ST_OVPD;
  endsequence

  drv_tristate_a: assert property (!por_t |-> ##2 drv_hiz_out) // R02
    else $error("drivers not tristated after ready loss");
  oc_to_hiccup_a: assert property ( // R05
    oc_sample && por_t && !ovr_t && !tsd_t &&
    (state_reg == bfsc_pkg::ST_SOFT || state_reg == bfsc_pkg::ST_RUN)
    |=> state_reg == bfsc_pkg::ST_HICC && overcurrent_trip_out)
    else $error("overcurrent did not enter hiccup");
  hiccup_hold_a: assert property ( // R06
    state_reg == bfsc_pkg::ST_HICC |=> ss_discharge_out)
    else $error("soft-start not held low in hiccup");
  oc_blank_a: assert property ( // R08
    oc_sample |-> $past(ls_on_out, 7))
    else $error("overcurrent sampled inside blanking");
  min_on_a: assert property ($rose(hs_on_out) |-> hs_on_out[*2]) // R21
    else $error("control pulse shorter than minimum");
  pg_window_a: assert property (!pg_ok |=> !pg_rel_reg) // R11
    else $error("power good released outside window");
  pg_delay_a: assert property ( // R14
    $rose(pg_rel_reg) |-> $past(pg_cnt_reg) == 9'(`BFSC_PG_DELAY))
    else $error("power good released before delay");
  ovp_discharge_a: assert property ( // R15
    s_ovp_enter |=> ls_on_out && !hs_on_out)
    else $error("overvoltage drive state wrong");
  ovp_latch_a: assert property ( // R16
    state_reg == bfsc_pkg::ST_OVPL && por_t
    |=> state_reg == bfsc_pkg::ST_OVPL ##1 !hs_on_out && !ls_on_out)
    else $error("overvoltage latch left early");
  thermal_off_a: assert property ( // R09
    state_reg == bfsc_pkg::ST_THRM |=> !hs_on_out && !ls_on_out)
    else $error("switches active in thermal shutdown");
  prebias_ls_a: assert property ( // R24
    state_reg == bfsc_pkg::ST_SOFT && pb_step_reg == 3'h0
    |=> !ls_on_out)
    else $error("low side on before first control pulse");
endmodule

/* File: common/bfsc_regs.svh */
// timing and sequencing constants for the buck fault and startup control
// How it works
// (R01) oscillator period resistor-set, 250 to 1500 kHz
// (R02) enable low tristates both gate drivers
// (R03) soft-start low stops switching until cycled
// (R04) overcurrent when setpoint negative, low side on
// (R05) overcurrent latches trip flag, enters hiccup
// (R06) hiccup holds soft-start low 4096 cycles
// (R07) hiccup repeats while the overload persists
// (R08) overcurrent sampling blanked 160 ns after low-side
// (R09) overtemperature turns switches off, discharges soft-start
// (R10) restart automatically after temperature falls back
// (R11) output good only inside sense window
// (R12) power good is open drain, released when good
// (R13) power good needs soft-start delay level too
// (R14) power good waits 256 cycles in window
// (R15) overvoltage: high side off, low side on
// (R16) after discharge both off until ready cycles
// (R17) external clock rising edges align the oscillator
// (R18) external clock used only after pre-bias startup
// (R19) no external clock: free-run on resistor
// (R20) external clock pulses wider than 100 ns
// (R21) no control pulse shorter than minimum on-time
// (R22) ready needs bias and enable; starts soft-start
// (R23) overcurrent protection active during soft-start ramp
// (R24) pre-bias: low side off, then duty steps
// (R25) comparators sampled and counted on switching cycles; the overcurrent comparator and its blanking count use every clock
`ifndef BFSC_REGS_SVH
`define BFSC_REGS_SVH
// ==========================================================
// clock and oscillator
`define BFSC_CLK_KHZ        40000
`define BFSC_FMIN_KHZ       250
`define BFSC_FMAX_KHZ       1500
`define BFSC_PER_MAX        (`BFSC_CLK_KHZ / `BFSC_FMIN_KHZ)
`define BFSC_PER_MIN \
  ((`BFSC_CLK_KHZ + `BFSC_FMAX_KHZ - 1) / `BFSC_FMAX_KHZ)
// ==========================================================
// times in ns and their cycle counts
`define BFSC_CLK_NS         25
`define BFSC_BLANK_NS       160
`define BFSC_BLANK_CYC \
  ((`BFSC_BLANK_NS + `BFSC_CLK_NS - 1) / `BFSC_CLK_NS)
`define BFSC_MINON_NS       50
`define BFSC_MINON_CYC \
  ((`BFSC_MINON_NS + `BFSC_CLK_NS - 1) / `BFSC_CLK_NS)
// ==========================================================
// switching-cycle counts; the sync timeout counts clock cycles
`define BFSC_HICCUP_CYC     4096
`define BFSC_PG_DELAY       256
`define BFSC_PB_N1          32
`define BFSC_PB_N2          16
`define BFSC_PB_N3          8
`define BFSC_EXT_TIMEOUT    (2 * `BFSC_PER_MAX)
`endif

/* File: common/bfsc_pkg.sv */
// types shared by the buck fault and startup control
package bfsc_pkg;
  typedef enum logic [6:0] {
    ST_OFF  = 7'h01,
    ST_SOFT = 7'h02,
    ST_RUN  = 7'h04,
    ST_HICC = 7'h08,
    ST_THRM = 7'h10,
    ST_OVPD = 7'h20,
    ST_OVPL = 7'h40
  } bfsc_state_t;
endpackage

/* File: verilog/bfsc_sync3.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module bfsc_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
          s1_reg[i]    <= 1'b0;
          s2_reg[i]    <= 1'b0;
          s3_reg[i]    <= 1'b0;
          level_out[i] <= 1'b0;
        end else begin
          s1_reg[i] <= pin_in[i];
          s2_reg[i] <= s1_reg[i];
          s3_reg[i] <= s2_reg[i];
          // a change counts only once two late stages agree
          if (s2_reg[i] == s3_reg[i]) begin
            level_out[i] <= s3_reg[i];
          end
        end
      end
    end
  endgenerate
endmodule

/* File: verilog/bfsc_osc.sv */
// switching oscillator with optional external alignment
`timescale 1ns/1ps
`include "bfsc_regs.svh"
module bfsc_osc (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  // period and alignment
  input  wire logic [7:0] period_in,
  input  wire logic       align_en_in,
  input  wire logic       align_edge_in,
  // cycle outputs
  output logic            tick_out,
  output logic      [7:0] phase_out,
  output logic      [7:0] period_out
);
  logic [7:0] per_next;

  // clamp keeps the rate inside the supported range
  always_comb begin
    per_next = period_in;
    if (period_in < 8'(`BFSC_PER_MIN)) per_next = 8'(`BFSC_PER_MIN); // R01
    if (period_in > 8'(`BFSC_PER_MAX)) per_next = 8'(`BFSC_PER_MAX); // R01
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      phase_out  <= 8'h00;
      tick_out   <= 1'b0;
      period_out <= 8'(`BFSC_PER_MAX);
    end else if ((align_en_in && align_edge_in) ||
                 (phase_out >= period_out - 8'h01)) begin
      // rising external edge restarts the cycle
      phase_out  <= 8'h00; // R17
      tick_out   <= 1'b1;
      period_out <= per_next; // R19
    end else begin
      phase_out <= phase_out + 8'h01;
      tick_out  <= 1'b0;
    end
  end
endmodule

/* File: verification/bfsc_board_model.sv */
// board side model: power-good pull-up and external sync clock source
`timescale 1ns/1ps
module bfsc_board_model #(
  parameter int EXT_HIGH_NS = 200,
  parameter int EXT_LOW_NS  = 450
) (
  // sync source control
  input  wire logic ext_run_in,
  // open-drain power good pin
  input  wire logic pg_drive_in,
  input  wire logic pg_oe_n_in,
  output logic      pg_pin_out,
  // sync clock to the device
  output logic      ext_clk_out
);
  // ==========================================================
  // pull-up wins whenever the device lets go of the pin
  assign pg_pin_out = pg_oe_n_in ? 1'b1 : pg_drive_in;
  // ==========================================================
  // source stands low between bursts; high phase kept above 100 ns
  initial begin
    ext_clk_out = 1'b0;
    forever begin
      wait (ext_run_in);
      ext_clk_out = 1'b1;
      #(EXT_HIGH_NS);
      ext_clk_out = 1'b0;
      #(EXT_LOW_NS);
    end
  end
endmodule

/* File: verification/tb.sv */
// self-checking bench for the buck fault and startup control
`timescale 1ns/1ps
module tb;
  // shortest switching period keeps the hiccup count affordable
  localparam int P = 27;
  logic       clk_in, nrst_in, vcc_ok, en_ok, ss_low, ss_dly;
  logic       oc_neg, hot, win, over, rel, ext_run;
  logic [7:0] per, duty;
  logic       hs, ls, hiz, ssd, oc_t, ov_t, por, ext_act;
  logic       pg_drv, pg_oe_n, pg_lvl, pg_pin, ext_clk;
  int         n_fail, checked, cyc;

  bfsc_top bfsc_top_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .vcc_ok_in(vcc_ok),
    .enable_ok_in(en_ok), .ss_low_in(ss_low), .ss_delay_in(ss_dly),
    .ocset_neg_in(oc_neg), .overtemp_in(hot), .sense_window_in(win),
    .sense_over_in(over), .sense_release_in(rel), .ext_clk_in(ext_clk),
    .freq_resistor_period_in(per), .duty_in(duty), .hs_on_out(hs),
    .ls_on_out(ls), .drv_hiz_out(hiz), .ss_discharge_out(ssd),
    .overcurrent_trip_out(oc_t), .overvoltage_trip_out(ov_t),
    .power_on_ready_out(por), .ext_sync_active_out(ext_act),
    .power_good_in(pg_pin), .power_good_out(pg_drv),
    .power_good_oe_n_out(pg_oe_n), .power_good_level_out(pg_lvl));

  bfsc_board_model bfsc_board_model_inst (
    .ext_run_in(ext_run), .pg_drive_in(pg_drv), .pg_oe_n_in(pg_oe_n),
    .pg_pin_out(pg_pin), .ext_clk_out(ext_clk));

  // ==========================================================
  // clock and hang guard
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial cyc = 0;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 150000) begin
      n_fail++;
      wrap_up();
    end
  end

  // ==========================================================
  // shared helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n * P) @(negedge clk_in);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    nrst_in = 1'b0;
    repeat (5) @(negedge clk_in);
    chk({hs, ls, hiz, ssd, oc_t, ov_t, pg_oe_n, pg_pin}, 8'h20);
    nrst_in = 1'b1;
    $display("test reset done");
  endtask
  task automatic t_start();
    int   i;
    logic bad;
    vcc_ok = 1'b1;
    ticks(5);
    chk({por, hiz}, 2'b01);
    en_ok = 1'b1;
    for (i = 0; i < 10 * P && por !== 1'b1; i++) @(negedge clk_in);
    chk(por, 1'b1);
    bad = 1'b0;
    for (i = 0; i < 20 * P && hs !== 1'b1; i++) begin
      if (ls !== 1'b0) bad = 1'b1;
      @(negedge clk_in);
    end
    chk({bad, hs, hiz}, 3'b010);
    ticks(70);
    $display("test start done");
  endtask
  task automatic t_pgood();
    int i;
    win = 1'b1;
    ticks(20);
    chk(pg_oe_n, 1'b0);
    ss_dly = 1'b1;
    for (i = 0; i < 300 * P && pg_oe_n !== 1'b1; i++) @(negedge clk_in);
    chk(i >= 255 * P && i <= 262 * P, 1'b1);
    chk({pg_pin, pg_drv}, 2'b10);
    ticks(1);
    chk(pg_lvl, 1'b1);
    win = 1'b0;
    for (i = 0; i < 3 * P && pg_oe_n !== 1'b0; i++) @(negedge clk_in);
    chk(pg_pin, 1'b0);
    win = 1'b1;
    $display("test power good done");
  endtask
  task automatic t_sslow();
    int   i;
    logic bad;
    ss_low = 1'b1;
    ticks(3);
    bad = 1'b0;
    for (i = 0; i < 5 * P; i++) begin
      if (hs !== 1'b0) bad = 1'b1;
      @(negedge clk_in);
    end
    chk(bad, 1'b0);
    // sync source arrives while the restart is still in pre-bias
    ext_run = 1'b1;
    ss_low = 1'b0;
    ticks(20);
    chk(ext_act, 1'b0);
    ticks(50);
    chk(ext_act, 1'b1);
    $display("test soft-start shutdown done");
  endtask
  task automatic t_ext();
    int   i;
    logic bad;
    ext_run = 1'b0;
    repeat (290) @(negedge clk_in);
    chk(ext_act, 1'b1);
    for (i = 0; i < 120 && ext_act !== 1'b0; i++) @(negedge clk_in);
    chk(ext_act, 1'b0);
    // duty changes only in the off phase so no pulse is clipped
    for (i = 0; i < P && ls !== 1'b1; i++) @(negedge clk_in);
    chk(ls, 1'b1);
    duty = 8'h12;
    bad = 1'b0;
    for (i = 0; i < 3 * P; i++) begin
      if (hs !== 1'b0) bad = 1'b1;
      @(negedge clk_in);
    end
    chk(bad, 1'b0);
    for (i = 0; i < 2 * P && ls !== 1'b0; i++) @(negedge clk_in);
    duty = 8'h80;
    $display("test sync loss done");
  endtask
  task automatic t_therm();
    int i;
    hot = 1'b1;
    for (i = 0; i < 4 * P && ssd !== 1'b1; i++) @(negedge clk_in);
    ticks(1);
    chk({hs, ls, ssd}, 3'b001);
    ticks(5);
    chk({hs, ls, ssd}, 3'b001);
    hot = 1'b0;
    for (i = 0; i < 4 * P && ssd !== 1'b0; i++) @(negedge clk_in);
    chk(ssd, 1'b0);
    ticks(70);
    $display("test thermal done");
  endtask
  task automatic t_ovp();
    int i;
    over = 1'b1;
    rel = 1'b0;
    for (i = 0; i < 4 * P && ov_t !== 1'b1; i++) @(negedge clk_in);
    ticks(1);
    chk({ov_t, hs, ls}, 3'b101);
    over = 1'b0;
    ticks(5);
    chk({hs, ls}, 2'b01);
    rel = 1'b1;
    ticks(15);
    chk({hs, ls}, 2'b00);
    en_ok = 1'b0;
    ticks(3);
    chk({por, hiz, hs, ls}, 4'h4);
    en_ok = 1'b1;
    ticks(75);
    chk({ov_t, hiz}, 2'b00);
    $display("test overvoltage done");
  endtask
  task automatic t_ocp();
    int i;
    oc_neg = 1'b1;
    for (i = 0; i < 3 * P && oc_t !== 1'b1; i++) @(negedge clk_in);
    chk(oc_t, 1'b1);
    oc_neg = 1'b0;
    repeat (3) @(negedge clk_in);
    chk({ssd, hs, ls}, 3'b100);
    repeat (4090 * P) @(negedge clk_in);
    chk({oc_t, ssd}, 2'b11);
    for (i = 0; i < 12 * P && oc_t !== 1'b0; i++) @(negedge clk_in);
    // the discharge switch follows the state one clock later
    @(negedge clk_in);
    chk({oc_t, ssd}, 2'b00);
    // overload still present during the new ramp
    oc_neg = 1'b1;
    for (i = 0; i < 80 * P && oc_t !== 1'b1; i++) @(negedge clk_in);
    chk(oc_t, 1'b1);
    $display("test overcurrent done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    n_fail = 0;
    checked = 0;
    nrst_in = 1'b0;
    {vcc_ok, en_ok, ss_low, ss_dly, oc_neg, hot, win, over} = 8'h00;
    rel = 1'b1;
    ext_run = 1'b0;
    per = 8'h1B;
    duty = 8'h80;
    @(negedge clk_in);
    t_reset();
    t_start();
    t_pgood();
    t_sslow();
    t_ext();
    t_therm();
    t_ovp();
    t_ocp();
    wrap_up();
  end
endmodule
